// [rtl/cadcr_pkg.sv]
// Constants and carrier types for the charger converter result registers.
// Assumes one system clock and a synchronous active-high reset.
//
// Notes on behaviour
// - Battery sense reading: unsigned, 1 mV steps.
// - System rail reading at 0x3D, reset zero.
// - Thermistor ratio in 0.0976563 percent steps.
// - Die temperature signed, half-degree steps.
// - Positive data-line reading at 0x43, reset zero.
// - Negative data-line reading at 0x45, reset zero.
// - Decode two 3-bit data-line driver fields.
`default_nettype none

package cadcr_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CADCR_OFS_BATT  = 8'h3B;
   localparam logic [7:0] CADCR_OFS_SYS   = 8'h3D;
   localparam logic [7:0] CADCR_OFS_THERM = 8'h3F;
   localparam logic [7:0] CADCR_OFS_DIE   = 8'h41;
   localparam logic [7:0] CADCR_OFS_POS   = 8'h43;
   localparam logic [7:0] CADCR_OFS_NEG   = 8'h45;
   localparam logic [7:0] CADCR_OFS_DRV   = 8'h47;

   localparam logic [15:0] CADCR_RESULT_RST = 16'h0000;
   localparam logic [7:0]  CADCR_DRV_RST    = 8'h00;

   // ----------------------------------------------------------------
   // Driver control field layout
   // ----------------------------------------------------------------
   localparam int CADCR_POS_SEL_LSB = 5;
   localparam int CADCR_NEG_SEL_LSB = 2;
   localparam int CADCR_SEL_W       = 3;
   // Number of drive-level outputs per line (one-hot over codes 1..6; code 0 sets no bit)
   localparam int CADCR_LEVELS      = 7;

   // ----------------------------------------------------------------
   // Driver codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CADCR_DRV_HIZ   = 3'h0,
      CADCR_DRV_GND   = 3'h1,
      CADCR_DRV_0V6   = 3'h2,
      CADCR_DRV_1V2   = 3'h3,
      CADCR_DRV_2V0   = 3'h4,
      CADCR_DRV_2V7   = 3'h5,
      CADCR_DRV_3V3   = 3'h6,
      CADCR_DRV_SPEC  = 3'h7
   } cadcr_drv_e;

   // Latest conversion results from the converter
   typedef struct packed {
      logic [15:0] battery_remote_sense;
      logic [15:0] system_rail_code;
      logic [15:0] thermistor_ratio_code;
      logic [15:0] die_temperature_code;
      logic [15:0] positive_line_code;
      logic [15:0] negative_line_code;
   } cadcr_results_s;

   // Decoded drive request for one data line
   typedef struct packed {
      logic                    drive_en;
      logic [CADCR_LEVELS-1:0] level_onehot;
      logic                    special;
   } cadcr_line_drive_s;

endpackage

`default_nettype wire

// [rtl/cadcr_drv_decode.sv]
// Decoder from a 3-bit driver select to a one-line drive request.
// Assumes the select comes from a register; output is combinational.
`default_nettype none

module cadcr_drv_decode (
   // Select code
   input  wire logic [2:0]               i_sel,
   // Decoded request
   output cadcr_pkg::cadcr_line_drive_s  o_drive
);

   wire logic                               is_hiz;
   wire logic                               is_spec;
   // One net gathers the per-code bits so the struct output has one driver
   wire logic [cadcr_pkg::CADCR_LEVELS-1:0] lvl_hot;

   assign is_hiz  = (i_sel == cadcr_pkg::CADCR_DRV_HIZ);
   assign is_spec = (i_sel == cadcr_pkg::CADCR_DRV_SPEC);

   // ----------------------------------------------------------------
   // Level decode
   // ----------------------------------------------------------------
   // code to level
   genvar g;
   generate
      for (g = 0; g < cadcr_pkg::CADCR_LEVELS; g++) begin : g_lvl
         assign lvl_hot[g] = (i_sel == 3'(g)) && !is_hiz;
      end
   endgenerate

   assign o_drive = '{drive_en:     !is_hiz && !is_spec,
                      level_onehot: lvl_hot,
                      special:      is_spec};

endmodule

`default_nettype wire

// [rtl/cadcr_regs.sv]
// Result register bank and data-line driver control register.
// Assumes a simple synchronous register port: one-cycle read and write
// strobes with a byte offset; read data appears one cycle after a read.
// Results arrive from the converter with a one-cycle update strobe.
`default_nettype none

module cadcr_regs (
   // Clock and reset
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_srst,
   // Register port
   input  wire logic                         i_reg_rd,
   input  wire logic                         i_reg_wr,
   input  wire logic [7:0]                   i_reg_addr,
   input  wire logic [15:0]                  i_reg_wdata,
   output logic      [15:0]                  o_reg_rdata,
   output logic                              o_reg_rvalid,
   output logic                              o_reg_hit,
   // Converter results
   input  wire logic                         i_conv_update,
   input  wire cadcr_pkg::cadcr_results_s    i_conv_results,
   // Data-line drivers
   output cadcr_pkg::cadcr_line_drive_s      o_pos_drive,
   output cadcr_pkg::cadcr_line_drive_s      o_neg_drive,
   output logic                              o_lines_short
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   cadcr_pkg::cadcr_results_s   res_q;
   cadcr_pkg::cadcr_results_s   res_d;
   logic [7:0]                  drv_q;
   logic [7:0]                  drv_d;
   logic [15:0]                 rdata_d;
   logic                        hit_d;
   cadcr_pkg::cadcr_line_drive_s pos_dec;
   cadcr_pkg::cadcr_line_drive_s neg_dec;
   logic [2:0]                  pos_sel;
   logic [2:0]                  neg_sel;
   logic [2:0]                  neg_wr_sel;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire logic sel_batt  = (i_reg_addr == cadcr_pkg::CADCR_OFS_BATT);
   wire logic sel_sys   = (i_reg_addr == cadcr_pkg::CADCR_OFS_SYS);
   wire logic sel_therm = (i_reg_addr == cadcr_pkg::CADCR_OFS_THERM);
   wire logic sel_die   = (i_reg_addr == cadcr_pkg::CADCR_OFS_DIE);
   wire logic sel_pos   = (i_reg_addr == cadcr_pkg::CADCR_OFS_POS);
   wire logic sel_neg   = (i_reg_addr == cadcr_pkg::CADCR_OFS_NEG);
   wire logic sel_drv   = (i_reg_addr == cadcr_pkg::CADCR_OFS_DRV);
   wire logic sel_any   = sel_batt | sel_sys | sel_therm | sel_die
                          | sel_pos | sel_neg | sel_drv;

   // ----------------------------------------------------------------
   // Result capture
   // ----------------------------------------------------------------
   // Codes are stored verbatim; scaling and sign are the reader's job,
   // so no arithmetic sits in the path.
   assign res_d = i_conv_update ? i_conv_results : res_q;

   // ----------------------------------------------------------------
   // Driver control write
   // ----------------------------------------------------------------
   // Code 7 is reserved on the negative line; a write of it keeps the
   // previous select so the driver never sees an undefined level.
   assign neg_wr_sel = i_reg_wdata[cadcr_pkg::CADCR_NEG_SEL_LSB +: 3];
   always_comb begin
      drv_d = drv_q;
      if (i_reg_wr && sel_drv) begin
         drv_d = i_reg_wdata[7:0];
         if (neg_wr_sel == cadcr_pkg::CADCR_DRV_SPEC) begin
            drv_d[cadcr_pkg::CADCR_NEG_SEL_LSB +: 3] =
               drv_q[cadcr_pkg::CADCR_NEG_SEL_LSB +: 3];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // read without side effect
   always_comb begin
      rdata_d = 16'h0000;
      unique case (1'b1)
         sel_batt:  rdata_d = res_q.battery_remote_sense;
         sel_sys:   rdata_d = res_q.system_rail_code;
         sel_therm: rdata_d = res_q.thermistor_ratio_code;
         sel_die:   rdata_d = res_q.die_temperature_code;
         sel_pos:   rdata_d = res_q.positive_line_code;
         sel_neg:   rdata_d = res_q.negative_line_code;
         sel_drv:   rdata_d = {8'h00, drv_q};
         default:   rdata_d = 16'h0000;
      endcase
   end
   assign hit_d = (i_reg_rd | i_reg_wr) & sel_any;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // result writes ignored
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         res_q        <= {6{cadcr_pkg::CADCR_RESULT_RST}};
         drv_q        <= cadcr_pkg::CADCR_DRV_RST;
         o_reg_rdata  <= 16'h0000;
         o_reg_rvalid <= 1'b0;
         o_reg_hit    <= 1'b0;
      end else begin
         res_q        <= res_d;
         drv_q        <= drv_d;
         o_reg_rdata  <= i_reg_rd ? rdata_d : 16'h0000;
         o_reg_rvalid <= i_reg_rd;
         o_reg_hit    <= hit_d;
      end
   end

   // ----------------------------------------------------------------
   // Driver decode
   // ----------------------------------------------------------------
   assign pos_sel = drv_q[cadcr_pkg::CADCR_POS_SEL_LSB +: 3];
   assign neg_sel = drv_q[cadcr_pkg::CADCR_NEG_SEL_LSB +: 3];

   cadcr_drv_decode u_pos_dec (
      .i_sel   (pos_sel),
      .o_drive (pos_dec)
   );

   cadcr_drv_decode u_neg_dec (
      .i_sel   (neg_sel),
      .o_drive (neg_dec)
   );

   // Outputs registered to keep the analog drivers glitch-free
   // drive outputs
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_pos_drive   <= '0;
         o_neg_drive   <= '0;
         o_lines_short <= 1'b0;
      end else begin
         o_pos_drive   <= pos_dec;
         o_neg_drive   <= '{drive_en: neg_dec.drive_en,
                            level_onehot: neg_dec.level_onehot,
                            special: 1'b0};
         o_lines_short <= pos_dec.special;
      end
   end

endmodule

`default_nettype wire

// [tb/cadcr_regs_chk.sv]
// Checker for the result register bank, bound to cadcr_regs.
// Assumes the one-cycle register port and registered drive outputs.
`default_nettype none
module cadcr_regs_chk (
   // Clock and reset
   input wire logic                         i_clk_sys,
   input wire logic                         i_srst,
   // Register port
   input wire logic                         i_reg_rd,
   input wire logic                         i_reg_wr,
   input wire logic [7:0]                   i_reg_addr,
   input wire logic [15:0]                  i_reg_wdata,
   input wire logic [15:0]                  o_reg_rdata,
   input wire logic                         o_reg_rvalid,
   input wire logic                         o_reg_hit,
   // Converter and drivers
   input wire logic                         i_conv_update,
   input wire cadcr_pkg::cadcr_results_s    i_conv_results,
   input wire cadcr_pkg::cadcr_line_drive_s o_pos_drive,
   input wire cadcr_pkg::cadcr_line_drive_s o_neg_drive,
   input wire logic                         o_lines_short
);
   timeunit 1ns;
   timeprecision 1ps;
   wire drv_wr = i_reg_wr && i_reg_addr == 8'h47;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   // ------------------------------------------------------------
   // Read-back follows the latest conversion
   // ------------------------------------------------------------
   property rd_p(logic [7:0] a, int k);
      i_conv_update ##1 (i_reg_rd && !i_conv_update && i_reg_addr == a)
      |=> o_reg_rdata == $past(i_conv_results[95-16*k -: 16], 2);
   endproperty
   batt_read_a: assert property (rd_p(8'h3B, 0))
      else $error("battery reading wrong");
   sys_read_a: assert property (rd_p(8'h3D, 1))
      else $error("system reading wrong");
   therm_read_a: assert property (rd_p(8'h3F, 2))
      else $error("thermistor reading wrong");
   die_read_a: assert property (rd_p(8'h41, 3))
      else $error("die reading wrong");
   pos_read_a: assert property (rd_p(8'h43, 4))
      else $error("positive line reading wrong");
   neg_read_a: assert property (rd_p(8'h45, 5))
      else $error("negative line reading wrong");
   unmapped_read_a: assert property (i_reg_rd && i_reg_addr == 8'h48
      |=> o_reg_rvalid && !o_reg_hit && o_reg_rdata == 16'h0000)
      else $error("unmapped read answered");
   line_short_a: assert property (drv_wr |=> ##1
      o_lines_short == ($past(i_reg_wdata[7:5], 2) == 3'h7))
      else $error("short flag wrong");
   pos_level_a: assert property (drv_wr && i_reg_wdata[7:5] == 3'h3
      |=> ##1 o_pos_drive == 9'h110) else $error("positive drive wrong");
   neg_hiz_a: assert property (drv_wr && i_reg_wdata[4:2] == 3'h0
      |=> ##1 o_neg_drive == 9'h000) else $error("negative drive wrong");
   cover property (i_conv_update ##1 i_reg_rd);
   cover property (o_lines_short);
   cover property (o_reg_rvalid && !o_reg_hit);
endmodule
bind cadcr_regs cadcr_regs_chk u_chk (.i_clk_sys, .i_srst, .i_reg_rd,
   .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
   .o_reg_hit, .i_conv_update, .i_conv_results, .o_pos_drive, .o_neg_drive,
   .o_lines_short);
`default_nettype wire

// [tb/test_charger_adc_result_regs.sv]
// Self-checking bench for the result register bank.
// Assumes the checker file is compiled before it.
`default_nettype none
module test_charger_adc_result_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic                         i_clk_sys = 1'b0;
   logic                         i_srst = 1'b1;
   logic                         i_reg_rd = 1'b0;
   logic                         i_reg_wr = 1'b0;
   logic                         i_conv_update = 1'b0;
   logic [7:0]                   i_reg_addr = 8'h00;
   logic [15:0]                  i_reg_wdata = 16'h0000;
   cadcr_pkg::cadcr_results_s    i_conv_results = 96'h0;
   logic [15:0]                  o_reg_rdata;
   logic                         o_reg_rvalid;
   logic                         o_reg_hit;
   cadcr_pkg::cadcr_line_drive_s o_pos_drive;
   cadcr_pkg::cadcr_line_drive_s o_neg_drive;
   logic                         o_lines_short;
   int                           n_fail = 0;
   int                           total_checks = 0;
   // Span ends: 20 V, 24 V, top ratio code, -40 C, 3.6 V
   logic [15:0] vals [6] = '{16'h4E20, 16'h5DC0, 16'h03FF, 16'hFFB0,
                             16'h0E10, 16'h0001};
   always #2.5 i_clk_sys = ~i_clk_sys;
   cadcr_regs u_dut (.i_clk_sys, .i_srst, .i_reg_rd, .i_reg_wr, .i_reg_addr,
      .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_reg_hit, .i_conv_update,
      .i_conv_results, .o_pos_drive, .o_neg_drive, .o_lines_short);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Every strobe is set at a falling edge, so one task drives each cycle
   task automatic drive(input logic r, input logic w, input logic u,
                        input logic [7:0] a, input logic [15:0] d);
      i_reg_rd = r;
      i_reg_wr = w;
      i_conv_update = u;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic h;
      h = (a >= cadcr_pkg::CADCR_OFS_BATT) && (a <= cadcr_pkg::CADCR_OFS_DRV)
          && a[0];
      drive(1'b1, 1'b0, 1'b0, a, 16'h0000);
      chk(o_reg_rdata, e);
      chk({15'h0000, o_reg_rvalid}, 16'h0001);
      chk({15'h0000, o_reg_hit}, {15'h0000, h});
   endtask
   function automatic logic [8:0] dexp(input logic [2:0] c);
      if (c == 3'h0) return 9'h000;
      if (c == 3'h7) return 9'h001;
      return {1'b1, 7'(7'h01 << c), 1'b0};
   endfunction
   task automatic t_reset_values();
      for (int i = 0; i < 7; i++) begin
         rd(8'(8'h3B + 2 * i), 16'h0000);
      end
      $display("reset values done");
   endtask
   task automatic t_results();
      i_conv_results = {vals[0], vals[1], vals[2], vals[3], vals[4], vals[5]};
      for (int i = 0; i < 6; i++) begin
         drive(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000);
         rd(8'(8'h3B + 2 * i), vals[i]);
      end
      drive(1'b0, 1'b1, 1'b0, 8'h3D, 16'h1234);
      chk(o_reg_rdata, 16'h0000);
      chk({14'h0000, o_reg_hit, o_reg_rvalid}, 16'h0002);
      rd(8'h3D, vals[1]);
      rd(8'h3D, vals[1]);
      rd(8'h48, 16'h0000);
      $display("results done");
   endtask
   task automatic t_driver();
      logic [2:0] n;
      for (int c = 0; c < 8; c++) begin
         n = (c == 7) ? 3'h6 : 3'(c);
         drive(1'b0, 1'b1, 1'b0, 8'h47, {8'h00, 3'(c), 3'(c), 2'h1});
         chk({14'h0000, o_reg_hit, o_reg_rvalid}, 16'h0002);
         rd(8'h47, {8'h00, 3'(c), n, 2'h1});
         chk({7'h00, o_pos_drive}, {7'h00, dexp(3'(c))});
         chk({7'h00, o_neg_drive}, {7'h00, dexp(n)});
         chk({15'h0000, o_lines_short}, {15'h0000, c == 7});
      end
      $display("driver codes done");
   endtask
   task automatic t_midrun_reset();
      i_srst = 1'b1;
      drive(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
      i_srst = 1'b0;
      chk({7'h00, o_pos_drive}, 16'h0000);
      chk({7'h00, o_neg_drive}, 16'h0000);
      chk({15'h0000, o_lines_short}, 16'h0000);
      rd(8'h47, 16'h0000);
      rd(8'h3B, 16'h0000);
      $display("mid-run reset done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(negedge i_clk_sys);
      i_srst = 1'b0;
      t_reset_values();
      t_results();
      t_driver();
      t_midrun_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
